// File: rpr_map.svh
`ifndef RPR_MAP_SVH
`define RPR_MAP_SVH

// Clock
`define RPR_CLK_NS 25
`define RPR_CYC_PER_MS (1000000 / `RPR_CLK_NS)

// Bus widths
`define RPR_ADDR_W 18
`define RPR_DQ_W 16
`define RPR_BANKS 16

// Mode register select, field positions and guard keys
`define RPR_MR0 3'h0
`define RPR_MR4 3'h4
`define RPR_MR4_HARD_BIT 13
`define RPR_MR4_SOFT_BIT 5
`define RPR_KEY_LOW 7'h7F
`define RPR_KEY0 5'h19
`define RPR_KEY1 5'h0F
`define RPR_KEY2 5'h17
`define RPR_KEY3 5'h07
`define RPR_KEY_LAST 2'h3

// Burst and qualification
`define RPR_BURST_CLKS 4
`define RPR_DQ_LOW 16'h0000
`define RPR_DQ_HIGH 16'hFFFF

// Link timing in clock cycles, some derived from ns, us or ms values
`define RPR_WL_CYC 12
`define RPR_TMOD_CYC 24
`define RPR_TRCD_CYC 8
`define RPR_TWR_RP_CYC 16
`define RPR_REFI_NS 7800
`define RPR_REFI_CYC (`RPR_REFI_NS / `RPR_CLK_NS)
`define RPR_PGM_X8_MS 1000
`define RPR_PGM_X16_MS 2000
`define RPR_PGM_X8_CYC (`RPR_PGM_X8_MS * `RPR_CYC_PER_MS)
`define RPR_PGM_X16_CYC (`RPR_PGM_X16_MS * `RPR_CYC_PER_MS)
`define RPR_PGM_EXIT_NS 15
`define RPR_PGM_EXIT_CYC ((`RPR_PGM_EXIT_NS + `RPR_CLK_NS - 1) / `RPR_CLK_NS)
`define RPR_PST_US 50
`define RPR_PST_CYC ((`RPR_PST_US * 1000 + `RPR_CLK_NS - 1) / `RPR_CLK_NS)

// Controller registers
`define RPR_REG_CTRL 4'h0
`define RPR_REG_STATUS 4'h4
`define RPR_REG_TARGET 4'h8
`define RPR_REG_MR0 4'hC
`define RPR_CTRL_START 0
`define RPR_CTRL_WRA 1
`define RPR_CTRL_SKIP 2
`define RPR_STATUS_BUSY 0
`define RPR_STATUS_DONE 1
`define RPR_TGT_BA_LSB 18
`define RPR_TGT_BG_LSB 20
`define RPR_TGT_W 22

`endif

// File: rpr_pkg.sv
`include "rpr_map.svh"
package rpr_pkg;

	typedef enum logic [2:0] {
		RPR_DES = 3'h0,
		RPR_MRS = 3'h1,
		RPR_ACT = 3'h2,
		RPR_WR = 3'h3,
		RPR_WRA = 3'h4,
		RPR_REF = 3'h5,
		RPR_PRE = 3'h6
	} rpr_cmd_t;

	typedef enum logic [1:0] {
		RPR_SPARE_NONE = 2'h0,
		RPR_SPARE_SOFT = 2'h1,
		RPR_SPARE_HARD = 2'h2
	} rpr_kind_t;

	function automatic logic [4:0] rpr_key_code(input logic [1:0] idx);
		case (idx)
			2'h0: rpr_key_code = `RPR_KEY0;
			2'h1: rpr_key_code = `RPR_KEY1;
			2'h2: rpr_key_code = `RPR_KEY2;
			default: rpr_key_code = `RPR_KEY3;
		endcase
	endfunction

endpackage

// File: rpr_if.sv
`timescale 1ns/100ps
`include "rpr_map.svh"
interface rpr_if;
	import rpr_pkg::*;
	rpr_cmd_t cmd;
	logic [1:0] bg;
	logic [1:0] ba;
	logic [`RPR_ADDR_W-1:0] addr;
	logic [`RPR_DQ_W-1:0] dq;
	logic dq_oe;
	modport ctrl (output cmd, output bg, output ba, output addr, output dq, output dq_oe);
	modport dev (input cmd, input bg, input ba, input addr, input dq, input dq_oe);
endinterface

// File: rpr_dram_end.sv
`timescale 1ns/100ps
`include "rpr_map.svh"
// Overview of operation
// - Hard repair reuses and clears bank soft spare
// - Hard spare is never overwritten; only reset clears it
// - Controller starts with banks idle, DBI/CRC off
// - MR4 bit 13 hard, bit 5 soft enable
// - Controller enters with hard repair mode only, soft mode off
// - Auto-precharge variant refreshes all banks outside the repaired bank pair
// - Plain write variant performs no refresh
// - Bank address bit 0 ignored for refresh exclusion
// - Only sequence commands are legal during repair
// - Controller holds DQ high after MR4 entry
// - Four MR0 guard keys, tMOD apart, uninterrupted
// - Guard key codes on A11..A7, A6:0 ones
// - Wrong or interrupted keys make cycle a no-op
// - After broken entry, ACT/WR act normally
// - Controller activates row, then writes same bank
// - All DQ low over burst bits repairs
// - All DQ high two clocks skips repair
// - Refresh only after WL+4+tWR+tRP
// - Refresh spacing; repaired bank not refreshed
// - Precharge after program time, then exit wait
// - MR4 bit 13 cleared, then wait exit time
// - Sequence repeatable; restore MR0 afterwards
// - Program, precharge-exit and mode-exit minimum times
module rpr_dram_end
	import rpr_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Command bus from the controller
	rpr_if.dev bus,
	// Spare row lookup
	input wire logic [3:0] i_lookup_bank,
	output logic [`RPR_ADDR_W-1:0] o_lookup_row,
	// Repair status
	output logic o_hard_mode,
	output logic o_soft_mode,
	output logic o_repair_armed,
	output logic o_repair_done,
	output logic o_repair_skipped,
	output logic o_repair_unknown,
	output logic o_normal_access,
	output logic [`RPR_BANKS-1:0] o_refresh_banks,
	output logic [2*`RPR_BANKS-1:0] o_spare_kinds
);

	typedef enum logic [7:0] {
		RPR_D_IDLE = 8'h01,
		RPR_D_KEY = 8'h02,
		RPR_D_NOP = 8'h04,
		RPR_D_ARMED = 8'h08,
		RPR_D_ROW = 8'h10,
		RPR_D_WL = 8'h20,
		RPR_D_DATA = 8'h40,
		RPR_D_PROG = 8'h80
	} rpr_dstate_t;

	rpr_dstate_t state_r;
	logic hard_r;
	logic soft_r;
	logic [1:0] key_idx_r;
	logic [3:0] tgt_r;
	logic [`RPR_ADDR_W-1:0] row_r;
	logic auto_r;
	logic [7:0] cnt_r;
	logic low_all_r;
	logic prev_high_r;
	logic two_high_r;
	rpr_kind_t kind_r [`RPR_BANKS];
	logic [`RPR_ADDR_W-1:0] spare_row_r [`RPR_BANKS];
	logic done_r;
	logic skipped_r;
	logic unknown_r;
	logic normal_r;
	logic [`RPR_BANKS-1:0] refresh_r;
	logic [`RPR_ADDR_W-1:0] lookup_r;

	// Command decode
	wire [3:0] cmd_bank = {bus.bg, bus.ba};
	wire [2:0] mr_sel = {bus.bg[0], bus.ba};
	wire is_des = (bus.cmd == RPR_DES);
	wire is_mrs = (bus.cmd == RPR_MRS);
	wire is_mr4 = is_mrs && (mr_sel == `RPR_MR4);
	wire is_act = (bus.cmd == RPR_ACT);
	wire is_wr = (bus.cmd == RPR_WR);
	wire is_wra = (bus.cmd == RPR_WRA);
	wire is_ref = (bus.cmd == RPR_REF);
	wire is_pre = (bus.cmd == RPR_PRE);
	wire key_ok = is_mrs && (cmd_bank == 4'h0)
		&& (bus.addr[11:7] == rpr_key_code(key_idx_r)) && (bus.addr[6:0] == `RPR_KEY_LOW);
	wire mr4_hard = bus.addr[`RPR_MR4_HARD_BIT];
	wire mr4_soft = bus.addr[`RPR_MR4_SOFT_BIT];

	// Burst qualification, a lane not driven counts as neither level
	wire dq_low = bus.dq_oe && (bus.dq == `RPR_DQ_LOW);
	wire dq_high = bus.dq_oe && (bus.dq == `RPR_DQ_HIGH);
	wire low_fin = low_all_r && dq_low;
	// Two consecutive high clocks anywhere in the burst are kept until the last beat
	wire high_fin = two_high_r || (prev_high_r && dq_high);
	wire last_beat = (state_r == RPR_D_DATA) && (cnt_r == 8'h00);
	wire commit = last_beat && low_fin;
	wire tgt_hard = (kind_r[tgt_r] == RPR_SPARE_HARD);
	wire do_write = commit && !tgt_hard;
	wire in_mode = (state_r != RPR_D_IDLE) && (state_r != RPR_D_NOP);

	// Refresh keep mask: the repaired bank and its bank-bit-0 partner are left out
	wire [`RPR_BANKS-1:0] keep_mask;
	generate
		for (genvar i = 0; i < `RPR_BANKS; i++) begin : g_bank
			assign keep_mask[i] = (4'(i) >> 1) != (tgt_r >> 1);
			assign o_spare_kinds[2*i +: 2] = kind_r[i];
		end
	endgenerate

	wire ref_normal = is_ref && !in_mode;
	wire ref_repair = is_ref && (state_r == RPR_D_PROG) && auto_r;
	wire [`RPR_BANKS-1:0] refresh_nxt = ref_normal ? {`RPR_BANKS{1'b1}} :
		ref_repair ? keep_mask : {`RPR_BANKS{1'b0}};

	// Mode register 4 and entry sequence
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			hard_r <= 1'b0;
			soft_r <= 1'b0;
		end else if (is_mr4) begin
			hard_r <= mr4_hard;
			soft_r <= mr4_soft;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= RPR_D_IDLE;
			key_idx_r <= 2'h0;
			tgt_r <= 4'h0;
			row_r <= '0;
			auto_r <= 1'b0;
			cnt_r <= 8'h00;
			low_all_r <= 1'b0;
			prev_high_r <= 1'b0;
			two_high_r <= 1'b0;
		end else if (is_mr4) begin
			key_idx_r <= 2'h0;
			state_r <= (mr4_hard || mr4_soft) ? RPR_D_KEY : RPR_D_IDLE;
		end else begin
			case (state_r)
				RPR_D_KEY: begin
					if (key_ok) begin
						key_idx_r <= key_idx_r + 2'h1;
						if (key_idx_r == `RPR_KEY_LAST) begin
							state_r <= RPR_D_ARMED;
						end
					end else if (!is_des) begin
						state_r <= RPR_D_NOP;
					end
				end
				RPR_D_ARMED: begin
					if (is_act) begin
						tgt_r <= cmd_bank;
						row_r <= bus.addr;
						state_r <= RPR_D_ROW;
					end
				end
				RPR_D_ROW: begin
					if ((is_wr || is_wra) && (cmd_bank == tgt_r)) begin
						auto_r <= is_wra;
						// The write is taken one edge after its cycle, so wait one less
						cnt_r <= 8'(`RPR_WL_CYC - 2);
						state_r <= RPR_D_WL;
					end
				end
				RPR_D_WL: begin
					if (cnt_r == 8'h00) begin
						cnt_r <= 8'(`RPR_BURST_CLKS - 1);
						low_all_r <= 1'b1;
						prev_high_r <= 1'b0;
						two_high_r <= 1'b0;
						state_r <= RPR_D_DATA;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				RPR_D_DATA: begin
					low_all_r <= low_fin;
					prev_high_r <= dq_high;
					two_high_r <= high_fin;
					cnt_r <= cnt_r - 8'h01;
					if (cnt_r == 8'h00) begin
						state_r <= RPR_D_PROG;
					end
				end
				RPR_D_PROG: begin
					if (is_pre) begin
						state_r <= RPR_D_NOP;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Spare records; hard entries would be fuses, a reset model clears them
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int b = 0; b < `RPR_BANKS; b++) begin
				kind_r[b] <= RPR_SPARE_NONE;
			end
		end else if (do_write) begin
			kind_r[tgt_r] <= hard_r ? RPR_SPARE_HARD : RPR_SPARE_SOFT;
		end
	end

	always_ff @(posedge i_clock) begin
		if (do_write) begin
			spare_row_r[tgt_r] <= row_r;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			done_r <= 1'b0;
			skipped_r <= 1'b0;
			unknown_r <= 1'b0;
			normal_r <= 1'b0;
			refresh_r <= '0;
			lookup_r <= '0;
		end else begin
			done_r <= commit;
			skipped_r <= last_beat && !low_fin && high_fin;
			unknown_r <= last_beat && !low_fin && !high_fin;
			normal_r <= !in_mode && !is_mr4 && (is_act || is_wr || is_wra);
			refresh_r <= refresh_nxt;
			lookup_r <= (kind_r[i_lookup_bank] == RPR_SPARE_NONE) ? '0 : spare_row_r[i_lookup_bank];
		end
	end

	assign o_hard_mode = hard_r;
	assign o_soft_mode = soft_r;
	assign o_repair_armed = (state_r == RPR_D_ARMED);
	assign o_repair_done = done_r;
	assign o_repair_skipped = skipped_r;
	assign o_repair_unknown = unknown_r;
	assign o_normal_access = normal_r;
	assign o_refresh_banks = refresh_r;
	assign o_lookup_row = lookup_r;

endmodule

// File: rpr_ctrl_end.sv
`timescale 1ns/100ps
`include "rpr_map.svh"
module rpr_ctrl_end
	import rpr_pkg::*;
#(
	parameter logic [31:0] P_PGM_CYC = `RPR_PGM_X8_CYC
)
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Avalon-MM slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Command bus to the memory
	rpr_if.ctrl bus
);

	typedef enum logic [11:0] {
		RPR_C_IDLE = 12'h001,
		RPR_C_MR4ON = 12'h002,
		RPR_C_KEY = 12'h004,
		RPR_C_ACT = 12'h008,
		RPR_C_WR = 12'h010,
		RPR_C_WL = 12'h020,
		RPR_C_DATA = 12'h040,
		RPR_C_REC = 12'h080,
		RPR_C_PGM = 12'h100,
		RPR_C_MR4OFF = 12'h200,
		RPR_C_MR0 = 12'h400,
		RPR_C_DONE = 12'h800
	} rpr_cstate_t;

	rpr_cstate_t state_r;
	logic [31:0] cnt_r;
	logic [31:0] ref_cnt_r;
	logic [1:0] key_idx_r;
	logic wra_r;
	logic skip_r;
	logic done_r;
	logic [`RPR_TGT_W-1:0] target_r;
	logic [`RPR_ADDR_W-1:0] mr0_r;
	rpr_cmd_t cmd_r;
	logic [1:0] bg_r;
	logic [1:0] ba_r;
	logic [`RPR_ADDR_W-1:0] addr_r;
	logic [`RPR_DQ_W-1:0] dq_r;
	logic dq_oe_r;
	logic rd_ack_r;
	logic [31:0] rdata_r;

	// Register decode
	wire wr_ctrl = i_avs_write && (i_avs_address == `RPR_REG_CTRL);
	wire wr_target = i_avs_write && (i_avs_address == `RPR_REG_TARGET);
	wire wr_mr0 = i_avs_write && (i_avs_address == `RPR_REG_MR0);
	wire idle = (state_r == RPR_C_IDLE);
	wire start = wr_ctrl && i_avs_writedata[`RPR_CTRL_START] && idle;
	wire rd_take = i_avs_read && !rd_ack_r;
	wire [31:0] status_word = (32'(done_r) << `RPR_STATUS_DONE) | (32'(!idle) << `RPR_STATUS_BUSY);
	wire [31:0] ctrl_word = (32'(wra_r) << `RPR_CTRL_WRA) | (32'(skip_r) << `RPR_CTRL_SKIP);
	wire [31:0] rd_mux = (i_avs_address == `RPR_REG_CTRL) ? ctrl_word :
		(i_avs_address == `RPR_REG_STATUS) ? status_word :
		(i_avs_address == `RPR_REG_TARGET) ? 32'(target_r) :
		(i_avs_address == `RPR_REG_MR0) ? 32'(mr0_r) : 32'h0000_0000;
	wire cnt_zero = (cnt_r == 32'h0000_0000);
	wire ref_due = wra_r && (ref_cnt_r == 32'h0000_0000);
	wire [3:0] tgt_bank = {target_r[`RPR_TGT_BG_LSB +: 2], target_r[`RPR_TGT_BA_LSB +: 2]};
	wire [`RPR_ADDR_W-1:0] mr4_on = `RPR_ADDR_W'(1) << `RPR_MR4_HARD_BIT;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wra_r <= 1'b1;
			skip_r <= 1'b0;
			target_r <= '0;
			mr0_r <= '0;
			rd_ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			rd_ack_r <= rd_take;
			if (rd_take) begin
				rdata_r <= rd_mux;
			end
			if (wr_ctrl && idle) begin
				wra_r <= i_avs_writedata[`RPR_CTRL_WRA];
				skip_r <= i_avs_writedata[`RPR_CTRL_SKIP];
			end
			if (wr_target && idle) begin
				target_r <= i_avs_writedata[`RPR_TGT_W-1:0];
			end
			if (wr_mr0 && idle) begin
				mr0_r <= i_avs_writedata[`RPR_ADDR_W-1:0];
			end
		end
	end

	// Sequencer, every command lasts one cycle and DES fills the gaps
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= RPR_C_IDLE;
			cnt_r <= 32'h0000_0000;
			ref_cnt_r <= 32'h0000_0000;
			key_idx_r <= 2'h0;
			done_r <= 1'b0;
			cmd_r <= RPR_DES;
			bg_r <= 2'h0;
			ba_r <= 2'h0;
			addr_r <= '0;
			dq_r <= `RPR_DQ_HIGH;
			dq_oe_r <= 1'b0;
		end else begin
			cmd_r <= RPR_DES;
			cnt_r <= cnt_zero ? cnt_r : cnt_r - 32'h0000_0001;
			case (state_r)
				RPR_C_IDLE: begin
					if (start) begin
						done_r <= 1'b0;
						state_r <= RPR_C_MR4ON;
					end
				end
				RPR_C_MR4ON: begin
					cmd_r <= RPR_MRS;
					{bg_r, ba_r} <= {1'b0, `RPR_MR4};
					addr_r <= mr4_on;
					dq_r <= `RPR_DQ_HIGH;
					dq_oe_r <= 1'b1;
					key_idx_r <= 2'h0;
					cnt_r <= `RPR_TMOD_CYC;
					state_r <= RPR_C_KEY;
				end
				RPR_C_KEY: begin
					if (cnt_zero) begin
						cmd_r <= RPR_MRS;
						{bg_r, ba_r} <= 4'h0;
						addr_r <= {6'h00, rpr_key_code(key_idx_r), `RPR_KEY_LOW};
						key_idx_r <= key_idx_r + 2'h1;
						cnt_r <= `RPR_TMOD_CYC;
						if (key_idx_r == `RPR_KEY_LAST) begin
							state_r <= RPR_C_ACT;
						end
					end
				end
				RPR_C_ACT: begin
					if (cnt_zero) begin
						cmd_r <= RPR_ACT;
						{bg_r, ba_r} <= tgt_bank;
						addr_r <= target_r[`RPR_ADDR_W-1:0];
						cnt_r <= `RPR_TRCD_CYC;
						state_r <= RPR_C_WR;
					end
				end
				RPR_C_WR: begin
					if (cnt_zero) begin
						cmd_r <= wra_r ? RPR_WRA : RPR_WR;
						addr_r <= '0;
						cnt_r <= `RPR_WL_CYC - 1;
						state_r <= RPR_C_WL;
					end
				end
				RPR_C_WL: begin
					if (cnt_zero) begin
						dq_r <= skip_r ? `RPR_DQ_HIGH : `RPR_DQ_LOW;
						cnt_r <= `RPR_BURST_CLKS - 1;
						state_r <= RPR_C_DATA;
					end
				end
				RPR_C_DATA: begin
					if (cnt_zero) begin
						dq_r <= `RPR_DQ_HIGH;
						cnt_r <= `RPR_TWR_RP_CYC;
						state_r <= RPR_C_REC;
					end
				end
				RPR_C_REC: begin
					if (cnt_zero) begin
						cnt_r <= P_PGM_CYC;
						ref_cnt_r <= 32'h0000_0000;
						state_r <= RPR_C_PGM;
					end
				end
				RPR_C_PGM: begin
					ref_cnt_r <= ref_due ? `RPR_REFI_CYC : ref_cnt_r - 32'h0000_0001;
					if (cnt_zero) begin
						cmd_r <= RPR_PRE;
						cnt_r <= `RPR_PGM_EXIT_CYC;
						state_r <= RPR_C_MR4OFF;
					end else if (ref_due) begin
						cmd_r <= RPR_REF;
					end
				end
				RPR_C_MR4OFF: begin
					if (cnt_zero) begin
						cmd_r <= RPR_MRS;
						{bg_r, ba_r} <= {1'b0, `RPR_MR4};
						addr_r <= '0;
						dq_oe_r <= 1'b0;
						cnt_r <= `RPR_PST_CYC;
						state_r <= RPR_C_MR0;
					end
				end
				RPR_C_MR0: begin
					if (cnt_zero) begin
						cmd_r <= RPR_MRS;
						{bg_r, ba_r} <= 4'h0;
						addr_r <= mr0_r;
						cnt_r <= `RPR_TMOD_CYC;
						state_r <= RPR_C_DONE;
					end
				end
				RPR_C_DONE: begin
					if (cnt_zero) begin
						done_r <= 1'b1;
						state_r <= RPR_C_IDLE;
					end
				end
				default: begin
					state_r <= RPR_C_IDLE;
				end
			endcase
		end
	end

	assign o_avs_waitrequest = rd_take;
	assign o_avs_readdata = rdata_r;
	assign bus.cmd = cmd_r;
	assign bus.bg = bg_r;
	assign bus.ba = ba_r;
	assign bus.addr = addr_r;
	assign bus.dq = dq_r;
	assign bus.dq_oe = dq_oe_r;

endmodule

// File: rpr_link_monitor.sv
`timescale 1ns/100ps
module rpr_link_monitor
	import rpr_pkg::*;
#(
	parameter logic [31:0] P_PGM_CYC = 32'h32
)
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Link signals
	input wire rpr_cmd_t cmd,
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [17:0] addr,
	input wire logic [15:0] dq,
	input wire logic dq_oe
);
	logic [31:0] wr_cnt_r;
	logic [15:0] ref_cnt_r;
	logic [15:0] exit_cnt_r;
	wire is_wr = cmd == RPR_WR || cmd == RPR_WRA;
	wire is_mr4 = cmd == RPR_MRS && {bg[0], ba} == 3'h4;
	wire is_exit = is_mr4 && !addr[13];
	// Counters saturate so a long idle spell never wraps into a false violation
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_cnt_r <= 32'hFFFFFFFF;
			ref_cnt_r <= 16'hFFFF;
			exit_cnt_r <= 16'hFFFF;
		end else begin
			wr_cnt_r <= is_wr ? 32'h1 : wr_cnt_r + {31'h0, wr_cnt_r != 32'hFFFFFFFF};
			ref_cnt_r <= (cmd == RPR_REF) ? 16'h1 : ref_cnt_r + {15'h0, ref_cnt_r != 16'hFFFF};
			exit_cnt_r <= is_exit ? 16'h1 : exit_cnt_r + {15'h0, exit_cnt_r != 16'hFFFF};
		end
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	sequence s_key(logic [4:0] k);
		cmd == RPR_MRS && bg == 2'h0 && ba == 2'h0 && addr[11:7] == k && addr[6:0] == 7'h7F;
	endsequence
	sequence s_low;
		(dq_oe && dq == 16'h0000) [*4];
	endsequence
	sequence s_high;
		(dq_oe && dq == 16'hFFFF) [*4];
	endsequence
	a_cmd_one_cycle: assert property (cmd != RPR_DES |=> cmd == RPR_DES)
		else $error("command held longer than one cycle");
	a_entry_dq_high: assert property (is_mr4 && addr[13] |=> (dq_oe && dq == 16'hFFFF) [*8])
		else $error("dq not high after entry");
	a_entry_one_mode: assert property (is_mr4 && addr[13] |-> !addr[5])
		else $error("both repair modes set");
	a_key_one_two: assert property (s_key(5'h19) |-> ##25 s_key(5'h0F))
		else $error("second key missing");
	a_key_two_three: assert property (s_key(5'h0F) |-> ##25 s_key(5'h17))
		else $error("third key missing");
	a_key_three_four: assert property (s_key(5'h17) |-> ##25 s_key(5'h07))
		else $error("fourth key missing");
	a_keys_to_act: assert property (s_key(5'h07) |-> ##25 cmd == RPR_ACT)
		else $error("activate not after keys");
	a_write_same_bank: assert property (
		cmd == RPR_ACT |-> ##9 is_wr && bg == $past(bg, 9) && ba == $past(ba, 9))
		else $error("write not to activated bank");
	a_burst_level: assert property (is_wr |-> ##12 (s_low or s_high))
		else $error("burst not all low or all high");
	a_ref_spacing: assert property (
		cmd == RPR_REF |-> ref_cnt_r >= 16'h004E && wr_cnt_r >= 32'h0000_0020)
		else $error("refresh too early");
	a_pre_after_pgm: assert property (cmd == RPR_PRE |-> wr_cnt_r >= P_PGM_CYC)
		else $error("precharge before program time");
	a_exit_release: assert property (is_exit |=> !dq_oe)
		else $error("dq still driven after exit");
	a_exit_wait: assert property (cmd != RPR_DES |-> exit_cnt_r >= 16'h07D0)
		else $error("command before exit time");
	c_refresh: cover property (cmd == RPR_REF);
endmodule

// File: dram_hard_row_repair_sequence_tb_top.sv
`timescale 1ns/100ps
module dram_hard_row_repair_sequence_tb_top;
	import rpr_pkg::*;
	localparam logic [31:0] PGM = 32'h32;
	localparam logic [4:0] KEYS [4] = '{5'h19, 5'h0F, 5'h17, 5'h07};
	logic i_clock;
	logic i_resetn;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	logic [3:0] lookup_bank;
	wire [17:0] rows [2];
	wire [31:0] kinds [2];
	wire [15:0] refm [2];
	wire [1:0] ev_done, ev_skip, ev_unk, ev_norm;
	wire [1:0] armed, hmode, smode;
	logic [19:0] notes [$];
	logic [31:0] rd;
	logic [15:0] lfsr;
	logic [3:0] b1;
	int fail_count;
	int tests_run;
	int cycles;
	rpr_if link1();
	rpr_if link2();
	rpr_ctrl_end #(.P_PGM_CYC(PGM)) rpr_ctrl_end_inst (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest), .bus(link1.ctrl));
	rpr_dram_end rpr_dram_end_inst (.i_clock(i_clock), .i_resetn(i_resetn), .bus(link1.dev),
		.i_lookup_bank(lookup_bank), .o_lookup_row(rows[0]), .o_hard_mode(hmode[0]),
		.o_soft_mode(smode[0]),
		.o_repair_armed(armed[0]), .o_repair_done(ev_done[0]), .o_repair_skipped(ev_skip[0]),
		.o_repair_unknown(ev_unk[0]), .o_normal_access(ev_norm[0]),
		.o_refresh_banks(refm[0]), .o_spare_kinds(kinds[0]));
	// Second end faces the bench so faults of the far side can be injected
	rpr_dram_end rpr_dram_end_inst_b (.i_clock(i_clock), .i_resetn(i_resetn), .bus(link2.dev),
		.i_lookup_bank(lookup_bank), .o_lookup_row(rows[1]), .o_hard_mode(hmode[1]),
		.o_soft_mode(smode[1]),
		.o_repair_armed(armed[1]), .o_repair_done(ev_done[1]), .o_repair_skipped(ev_skip[1]),
		.o_repair_unknown(ev_unk[1]), .o_normal_access(ev_norm[1]),
		.o_refresh_banks(refm[1]), .o_spare_kinds(kinds[1]));
	rpr_link_monitor #(.P_PGM_CYC(PGM)) rpr_link_monitor_inst (.i_clock(i_clock),
		.i_resetn(i_resetn), .cmd(link1.cmd), .bg(link1.bg), .ba(link1.ba), .addr(link1.addr),
		.dq(link1.dq), .dq_oe(link1.dq_oe));
	task automatic check(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic close_out;
		$display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic seen(input logic [19:0] got);
		logic [19:0] exp;
		exp = (notes.size() > 0) ? notes.pop_front() : 20'hFFFFF;
		check(got === exp, "unexpected link event");
	endtask
	always @(posedge i_clock) begin
		if (i_resetn === 1'b1) begin
			if (|ev_done) seen(20'h10000);
			if (|ev_skip) seen(20'h20000);
			if (|ev_unk) seen(20'h30000);
			if (|ev_norm) seen(20'h40000);
			if (|(refm[0] | refm[1])) seen({4'h5, refm[0] | refm[1]});
		end
	end
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			$display("[ERR] %0t run took too long", $time);
			close_out();
		end
	end
	// Bus cycle: request held until waitrequest is seen low at a rising edge
	task automatic av(input logic r, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_read <= r;
		avs_write <= !r;
		avs_writedata <= d;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge i_clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic ctrl_repair(input logic [3:0] bk, input logic [17:0] row, input logic wra, input logic skip);
		int n;
		notes.push_back(skip ? 20'h20000 : 20'h10000);
		if (wra && !skip) notes.push_back({4'h5, 16'hFFFF & ~(16'h3 << {bk[3:1], 1'b0})});
		av(1'b0, 4'h8, {10'h0, bk, row});
		av(1'b0, 4'h0, {29'h0, skip, wra, 1'b1});
		n = 0;
		do begin
			av(1'b1, 4'h4, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 3000);
		check(rd[1:0] === 2'b10, "repair did not finish");
	endtask
	task automatic spare(input int i, input logic [3:0] bk, input logic [1:0] kd, input logic [17:0] row);
		lookup_bank <= bk;
		repeat (2) @(posedge i_clock);
		check(kinds[i][2*bk +: 2] === kd && rows[i] === row, "spare record mismatch");
	endtask
	task automatic cmd2(input rpr_cmd_t c, input logic [3:0] bk, input logic [17:0] a, input int gap);
		link2.cmd <= c;
		{link2.bg, link2.ba} <= bk;
		link2.addr <= a;
		@(posedge i_clock);
		link2.cmd <= RPR_DES;
		repeat (gap - 1) @(posedge i_clock);
	endtask
	task automatic dev_repair(input logic [17:0] mr4, input logic brk, input logic [3:0] bk,
		input logic [17:0] row, input logic [15:0] dv);
		int k;
		link2.dq_oe <= 1'b1;
		cmd2(RPR_MRS, 4'h4, mr4, 24);
		check({hmode[1], smode[1]} === {mr4[13], mr4[5]}, "mode bits");
		// Broken entry swaps the middle keys
		for (k = 0; k < 4; k++) begin
			cmd2(RPR_MRS, 4'h0, {6'h0, KEYS[brk && (k == 1 || k == 2) ? 3 - k : k], 7'h7F}, 24);
		end
		check(armed[1] === !brk, "arming state");
		cmd2(RPR_ACT, bk, row, 8);
		cmd2(RPR_WRA, bk, 18'h0, 12);
		link2.dq <= dv;
		repeat (4) @(posedge i_clock);
		link2.dq <= 16'hFFFF;
		repeat (20) @(posedge i_clock);
		cmd2(RPR_PRE, bk, 18'h0, 2);
		link2.dq_oe <= 1'b0;
		cmd2(RPR_MRS, 4'h4, 18'h0, 30);
	endtask
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial begin
		i_resetn = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata, lookup_bank} = '0;
		{link2.bg, link2.ba, link2.addr, link2.dq_oe} = '0;
		link2.cmd = RPR_DES;
		link2.dq = 16'hFFFF;
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		lfsr = 16'h0015;
		repeat (20) @(posedge i_clock);
		i_resetn <= 1'b1;
		@(posedge i_clock);
		av(1'b1, 4'h4, 32'h0);
		check(rd === 32'h0, "status after reset");
		av(1'b1, 4'h2, 32'h0);
		check(rd === 32'h0, "unmapped read");
		av(1'b0, 4'hC, 32'h00A30);
		av(1'b1, 4'hC, 32'h0);
		check(rd[17:0] === 18'h00A30, "restore value readback");
		spare(0, 4'h0, 2'h0, 18'h0);
		$display("Test registers finished");
		lfsr = lfsr_next(lfsr);
		b1 = lfsr[3:0];
		ctrl_repair(b1, {lfsr[1:0], lfsr}, 1'b1, 1'b0);
		spare(0, b1, 2'h2, {lfsr[1:0], lfsr});
		ctrl_repair(b1, ~{lfsr[1:0], lfsr}, 1'b1, 1'b0);
		spare(0, b1, 2'h2, {lfsr[1:0], lfsr});
		ctrl_repair(b1 ^ 4'h5, 18'h1234, 1'b0, 1'b1);
		spare(0, b1 ^ 4'h5, 2'h0, 18'h0);
		$display("Test controller repairs finished");
		notes.push_back(20'h10000);
		dev_repair(18'h00020, 1'b0, 4'h9, 18'h00111, 16'h0000);
		spare(1, 4'h9, 2'h1, 18'h00111);
		notes.push_back(20'h10000);
		dev_repair(18'h02000, 1'b0, 4'h9, 18'h00222, 16'h0000);
		spare(1, 4'h9, 2'h2, 18'h00222);
		notes.push_back(20'h40000);
		notes.push_back(20'h40000);
		dev_repair(18'h02000, 1'b1, 4'h9, 18'h00333, 16'h0000);
		spare(1, 4'h9, 2'h2, 18'h00222);
		notes.push_back(20'h30000);
		dev_repair(18'h02000, 1'b0, 4'h3, 18'h00444, 16'h00FF);
		spare(1, 4'h3, 2'h0, 18'h0);
		$display("Test device faults finished");
		repeat (10) @(posedge i_clock);
		check(notes.size() == 0, "expected event never seen");
		close_out();
	end
endmodule
